// file: include/wr_master_pkg.sv
// shared types and timing constants for the backplane write-cycle master
package wr_master_pkg;

    // clock period of the master's own logic
    localparam int CLK_PERIOD_NS   = 10;

    // bus timing figures in nanoseconds, as the bus defines them
    localparam int ADDR_SETUP_NS   = 15;    // address and function codes before strobe
    localparam int RW_EARLY_NS     = 75;    // direction may fall this early before strobe
    localparam int RW_LATE_NS      = 35;    // direction must fall by this after strobe
    localparam int DATA_SETUP_NS   = 15;    // data before first byte strobe
    localparam int AS_DS_MIN_NS    = 50;    // strobe to byte strobe, least
    localparam int AS_DS_MAX_NS    = 2500;  // strobe to byte strobe, most
    localparam int RW_DS_NS        = 65;    // direction low before byte strobe
    localparam int NEGATE_MAX_NS   = 350;   // ack to strobe negation, most
    localparam int DATA_HOLD_NS    = 85;    // data kept after ack
    localparam int ADDR_HOLD_NS    = 15;    // address after last strobe rises
    localparam int RW_HOLD_NS      = 25;    // direction after last strobe rises
    localparam int ACK_LIMIT_NS    = 3000;  // ack deadline, ordinary cycle
    localparam int ACK_LIMIT_DMA_NS = 1500; // ack deadline, dma cycle
    localparam int AS_LOW_MAX_NS   = 3500;  // strobe low time, most
    localparam int BUS_ERROR_NS    = 4000;  // bus-error timer on the far side
    localparam int TAKEOVER_NS     = 100;   // quiet bus before a new cycle

    // least times round up, longest round down
    localparam int ADDR_SETUP_CYC  = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AS_DS_MIN_CYC   = (AS_DS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AS_DS_MAX_CYC   = AS_DS_MAX_NS / CLK_PERIOD_NS;
    localparam int RW_DS_CYC       = (RW_DS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_HOLD_CYC   = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_HOLD_CYC   = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RW_HOLD_CYC     = (RW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NEGATE_MAX_CYC  = NEGATE_MAX_NS / CLK_PERIOD_NS;
    localparam int ACK_LIMIT_CYC   = ACK_LIMIT_NS / CLK_PERIOD_NS;
    localparam int ACK_LIMIT_DMA_CYC = ACK_LIMIT_DMA_NS / CLK_PERIOD_NS;
    localparam int AS_LOW_MAX_CYC  = AS_LOW_MAX_NS / CLK_PERIOD_NS;
    localparam int TAKEOVER_CYC    = (TAKEOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // counter width, enough for the longest count above
    localparam int CNT_W           = 12;

    // idle level of every active-low bus line
    localparam logic LINE_IDLE     = 1'b1;

    // one write request from the user side
    typedef struct packed {
        logic [22:0] addr;          // word address, bits 1..23
        logic [2:0]  fc;            // function codes
        logic [15:0] data;          // write data
        logic        upper_en;      // write upper byte lane
        logic        lower_en;      // write lower byte lane
        logic        dma;           // dma cycle: shorter ack deadline
    } wr_req_t;

    // master-driven bus lines, all low-active except address and codes
    typedef struct packed {
        logic [22:0] addr;          // address lines
        logic [2:0]  function_code_lines;
        logic        read_write_dir;      // high read, low write
        logic        address_strobe_n;
        logic        upper_byte_strobe_n;
        logic        lower_byte_strobe_n;
    } bus_out_t;

endpackage

// file: rtl/sync_stage.sv
// two-flop synchroniser for asynchronous bus inputs
`timescale 1ns/100ps
`default_nettype none

module sync_stage #(
    parameter int           WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input  wire logic             clock_i,   // local clock
    input  wire logic             rstn_i,    // async reset, active low
    input  wire logic [WIDTH-1:0] async_i,   // raw pin levels
    output logic      [WIDTH-1:0] sync_o     // levels safe to decode
);

    logic [WIDTH-1:0] meta_q;  // first stage, read only by the second

    // both stages reset to the idle level so nothing looks active at release
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule
`default_nettype wire

// file: rtl/wr_master.sv
// bus master that runs asynchronous 16-bit backplane write cycles
`timescale 1ns/100ps
`default_nettype none

module wr_master #(
    parameter int AS_TO_DS_CYC = wr_master_pkg::AS_DS_MIN_CYC  // strobe to byte strobe
) (
    input  wire logic                    clock_i,             // 100 MHz clock
    input  wire logic                    rstn_i,              // async reset, active low
    // user side
    input  wire logic                    req_valid_i,         // write request present
    input  wire wr_master_pkg::wr_req_t  req_i,               // request contents
    output logic                         req_ready_o,         // request taken when both high
    output logic                         done_o,              // pulse: cycle acknowledged
    output logic                         bus_error_o,         // pulse: no ack in time
    output logic                         matched_o,           // a slave matched last cycle
    // bus side
    output var wr_master_pkg::bus_out_t  bus_o,               // address, codes, strobes
    output logic                         bus_oe_n_o,          // low while bus_o is driven
    output logic [15:0]                  data_lines_o,        // write data
    output logic                         data_oe_n_o,         // low while data is driven
    output logic                         transfer_ack_o,      // active pull-up level
    output logic                         transfer_ack_oe_n_o, // low while pulling ack high
    input  wire logic                    transfer_ack_n_i,    // ack line from slaves
    input  wire logic                    address_match_n_i    // match line from slaves
);
    import wr_master_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,     // waiting for a request, bus released
        ST_SETUP,    // address, codes, direction, data driven
        ST_AS_DLY,   // address strobe low, byte strobes pending
        ST_WAIT_ACK, // byte strobes low, waiting for ack
        ST_HOLD,     // strobes negated, lines held
        ST_GAP       // bus released, waiting for a quiet bus
    } state_t;

    localparam logic [CNT_W-1:0] SETUP_N   = CNT_W'(ADDR_SETUP_CYC);
    localparam logic [CNT_W-1:0] AS_DS_N   = CNT_W'(AS_TO_DS_CYC);
    localparam logic [CNT_W-1:0] HOLD_N    = CNT_W'(DATA_HOLD_CYC);
    localparam logic [CNT_W-1:0] GAP_N     = CNT_W'(TAKEOVER_CYC);
    localparam logic [CNT_W-1:0] LIMIT_N   = CNT_W'(ACK_LIMIT_CYC);
    localparam logic [CNT_W-1:0] LIMIT_D_N = CNT_W'(ACK_LIMIT_DMA_CYC);

    state_t           state_q;       // cycle sequencer
    logic [CNT_W-1:0] phase_cnt_q;   // cycles spent in the current phase
    logic [CNT_W-1:0] as_low_cnt_q;  // cycles with address strobe low
    logic [CNT_W-1:0] quiet_cnt_q;   // cycles with strobe and ack both high
    wr_req_t          req_q;         // request being run
    logic             ack_s;         // synchronised ack, active low
    logic             match_s;       // synchronised match, active low
    logic             ack_low;       // ack seen low this cycle
    logic             timeout;       // ack deadline reached

    // ack and match come from another party with no shared clock
    sync_stage #(
        .WIDTH     (2),
        .RESET_VAL ({LINE_IDLE, LINE_IDLE})
    ) u_sync (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .async_i ({transfer_ack_n_i, address_match_n_i}),
        .sync_o  ({ack_s, match_s})
    );

    assign ack_low = !ack_s;

    // deadline depends on the cycle kind; the far timer cannot tell them apart
    assign timeout = as_low_cnt_q >= (req_q.dma ? LIMIT_D_N : LIMIT_N);

    // phase counter restarts on every state change except the default recovery to ST_GAP
    function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] c);
        return (c == '1) ? c : c + CNT_W'(1);
    endfunction

    // sequencer: one ack ends one address strobe, never two
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q     <= ST_GAP;    // start with a takeover wait
            phase_cnt_q <= '0;
        end else begin
            phase_cnt_q <= step(phase_cnt_q);
            case (state_q)
                ST_IDLE: begin
                    if (req_valid_i && req_ready_o) begin
                        state_q     <= ST_SETUP;
                        phase_cnt_q <= '0;
                    end
                end
                ST_SETUP: begin
                    // address setup and direction lead before the strobe
                    if (phase_cnt_q == SETUP_N - CNT_W'(1)) begin
                        state_q     <= ST_AS_DLY;
                        phase_cnt_q <= '0;
                    end
                end
                ST_AS_DLY: begin
                    if (phase_cnt_q == AS_DS_N - CNT_W'(1)) begin
                        state_q     <= ST_WAIT_ACK;
                        phase_cnt_q <= '0;
                    end
                end
                ST_WAIT_ACK: begin
                    // ack or deadline both end the strobe at once
                    if (ack_low || timeout) begin
                        state_q     <= ST_HOLD;
                        phase_cnt_q <= '0;
                    end
                end
                ST_HOLD: begin
                    // data hold covers address and direction hold as well
                    if (phase_cnt_q == HOLD_N - CNT_W'(1)) begin
                        state_q     <= ST_GAP;
                        phase_cnt_q <= '0;
                    end
                end
                ST_GAP: begin
                    if (quiet_cnt_q >= GAP_N) begin
                        state_q     <= ST_IDLE;
                        phase_cnt_q <= '0;
                    end
                end
                default: begin
                    state_q <= ST_GAP;
                end
            endcase
        end
    end

    // request register, loaded only when a request is taken
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_q <= '0;
        end else if (state_q == ST_IDLE && req_valid_i && req_ready_o) begin
            req_q <= req_i;
        end
    end

    // ready is high only in idle; dropped as soon as a request is taken
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_ready_o <= 1'b0;
        end else if (state_q == ST_IDLE && req_valid_i && req_ready_o) begin
            req_ready_o <= 1'b0;
        end else if (state_q == ST_GAP && quiet_cnt_q >= GAP_N) begin
            req_ready_o <= 1'b1;
        end
    end

    // address strobe low time, also drives the ack deadline
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            as_low_cnt_q <= '0;
        end else if (!bus_o.address_strobe_n) begin
            as_low_cnt_q <= step(as_low_cnt_q);
        end else begin
            as_low_cnt_q <= '0;
        end
    end

    // quiet bus: our strobe high and the ack line seen high
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            quiet_cnt_q <= '0;
        end else if (bus_o.address_strobe_n && ack_s) begin
            quiet_cnt_q <= step(quiet_cnt_q);
        end else begin
            quiet_cnt_q <= '0;
        end
    end

    // address, codes and direction; direction falls with the address
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_o.addr                <= '0;
            bus_o.function_code_lines <= '0;
            bus_o.read_write_dir      <= LINE_IDLE;
            bus_oe_n_o                <= 1'b1;
        end else if (state_q == ST_IDLE && req_valid_i && req_ready_o) begin
            bus_o.addr                <= req_i.addr;
            bus_o.function_code_lines <= req_i.fc;
            bus_o.read_write_dir      <= 1'b0;
            bus_oe_n_o                <= 1'b0;
        end else if (state_q == ST_HOLD && phase_cnt_q == HOLD_N - CNT_W'(1)) begin
            // release after the hold; address and codes float at their last value, direction goes back high
            bus_o.read_write_dir      <= LINE_IDLE;
            bus_oe_n_o                <= 1'b1;
        end
    end

    // address strobe: low after setup, high on ack or deadline
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_o.address_strobe_n <= LINE_IDLE;
        end else if (state_q == ST_SETUP && phase_cnt_q == SETUP_N - CNT_W'(1)) begin
            bus_o.address_strobe_n <= 1'b0;
        end else if (state_q == ST_WAIT_ACK && (ack_low || timeout)) begin
            bus_o.address_strobe_n <= LINE_IDLE;
        end
    end

    // byte strobes: only the lanes asked for, both negate with the strobe
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_o.upper_byte_strobe_n <= LINE_IDLE;
            bus_o.lower_byte_strobe_n <= LINE_IDLE;
        end else if (state_q == ST_AS_DLY && phase_cnt_q == AS_DS_N - CNT_W'(1)) begin
            bus_o.upper_byte_strobe_n <= !req_q.upper_en;
            bus_o.lower_byte_strobe_n <= !req_q.lower_en;
        end else if (state_q == ST_WAIT_ACK && (ack_low || timeout)) begin
            bus_o.upper_byte_strobe_n <= LINE_IDLE;
            bus_o.lower_byte_strobe_n <= LINE_IDLE;
        end
    end

    // write data: driven from setup, well ahead of the byte strobes
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_lines_o <= '0;
            data_oe_n_o  <= 1'b1;
        end else if (state_q == ST_IDLE && req_valid_i && req_ready_o) begin
            data_lines_o <= req_i.data;
            data_oe_n_o  <= 1'b0;
        end else if (state_q == ST_HOLD && phase_cnt_q == HOLD_N - CNT_W'(1)) begin
            data_oe_n_o  <= 1'b1;
        end
    end

    // active pull-up on ack: never before our strobes are high again
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            transfer_ack_o      <= 1'b1;
            transfer_ack_oe_n_o <= 1'b1;
        end else if (state_q == ST_WAIT_ACK && (ack_low || timeout)) begin
            transfer_ack_oe_n_o <= 1'b0;
        end else if (state_q == ST_IDLE && req_valid_i && req_ready_o) begin
            transfer_ack_oe_n_o <= 1'b1;  // let slaves pull low freely
        end
    end

    // completion pulses; match is latched while the strobe is low
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_o      <= 1'b0;
            bus_error_o <= 1'b0;
            matched_o   <= 1'b0;
        end else begin
            done_o      <= state_q == ST_WAIT_ACK && ack_low;
            bus_error_o <= state_q == ST_WAIT_ACK && !ack_low && timeout;
            if (state_q == ST_SETUP) begin
                matched_o <= 1'b0;
            end else if (!bus_o.address_strobe_n && !match_s) begin
                matched_o <= 1'b1;
            end
        end
    end

    // checks on what this master drives
    logic ds_any_n;
    assign ds_any_n = bus_o.upper_byte_strobe_n & bus_o.lower_byte_strobe_n;

    a_addr_setup: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $fell(bus_o.address_strobe_n) |-> $past(!bus_oe_n_o, 2) && $stable(bus_o.addr))
        else $error("address not set up before strobe");
    a_rw_at_strobe: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $fell(bus_o.address_strobe_n) |-> !bus_o.read_write_dir && $past(!bus_o.read_write_dir, 2))
        else $error("direction not low around strobe");
    a_as_to_ds: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $fell(ds_any_n) |-> $past(!bus_o.address_strobe_n, 5))
        else $error("byte strobe too soon after address strobe");
    a_rw_before_ds: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $fell(ds_any_n) |-> $past(!bus_o.read_write_dir, 7))
        else $error("direction not low 65 ns before byte strobe");
    a_data_setup: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $fell(ds_any_n) |-> $past(!data_oe_n_o, 2) && $stable(data_lines_o))
        else $error("data not set up before byte strobe");
    a_ack_negate: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (!ds_any_n && ack_low) |=> bus_o.address_strobe_n && ds_any_n)
        else $error("strobes not negated after ack");
    a_data_hold: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $rose(bus_o.address_strobe_n) |-> (!data_oe_n_o && !bus_oe_n_o)[*8])
        else $error("data or address released too early");
    a_as_low_max: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !bus_o.address_strobe_n |-> as_low_cnt_q < CNT_W'(AS_LOW_MAX_CYC))
        else $error("address strobe low too long");
    a_quiet_gap: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $fell(bus_oe_n_o) |-> $past(quiet_cnt_q) >= GAP_N)
        else $error("new cycle without quiet bus");
    a_pullup_late: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !transfer_ack_oe_n_o |-> bus_o.address_strobe_n && ds_any_n)
        else $error("ack pulled up while strobes low");
    a_one_ack: assert property (@(posedge clock_i) disable iff (!rstn_i)
        done_o |-> bus_o.address_strobe_n ##1 bus_o.address_strobe_n)
        else $error("strobe held for a second ack");

    c_write_done: cover property (@(posedge clock_i) disable iff (!rstn_i)
        done_o && !req_q.dma);
    c_dma_done: cover property (@(posedge clock_i) disable iff (!rstn_i)
        done_o && req_q.dma);
    c_timeout: cover property (@(posedge clock_i) disable iff (!rstn_i)
        bus_error_o);
    c_upper_only: cover property (@(posedge clock_i) disable iff (!rstn_i)
        $fell(bus_o.upper_byte_strobe_n) && bus_o.lower_byte_strobe_n);

endmodule
`default_nettype wire

// file: bench/slave_model.sv
// behavioural slave card on the backplane write bus
`timescale 1ns/100ps
`default_nettype none
module slave_model #(
    parameter logic [2:0] PAGE = 3'h2  // top address bits this card answers
) (
    input  wire wr_master_pkg::bus_out_t bus_i,       // master's lines
    input  wire logic                    bus_oe_n_i,  // low while address driven
    input  wire logic [15:0]             data_i,      // data lines
    input  wire logic                    data_oe_n_i, // low while data driven
    input  wire logic [10:0]             delay_i,     // ns from byte strobe to ack
    output logic                         ack_low_o,   // pulls ack line low
    output logic                         match_low_o, // pulls match line low
    output logic [15:0]                  word_o,      // stored word
    output logic [7:0]                   faults_o     // master slips seen
);
    wire logic  sel   = bus_i.addr[22:20] == PAGE;
    wire logic  bds_n = bus_i.upper_byte_strobe_n & bus_i.lower_byte_strobe_n;
    logic [15:0] held;   // data seen at capture
    logic        acked;  // this card acknowledged the cycle
    logic        took;   // ack given, kept for the data hold check
    initial begin
        {ack_low_o, match_low_o, acked} = 3'h0;
        word_o = 16'h0000;
        faults_o = 8'h00;
    end
    // decode only while the strobe is low, well inside 70 ns
    always @(negedge bus_i.address_strobe_n) begin
        #30 match_low_o = sel & !bus_i.address_strobe_n;
    end
    // direction taken at byte strobe only: it may still move after address strobe
    always @(negedge bds_n) if (sel && !bus_i.address_strobe_n) begin
        #1;
        if (bus_i.read_write_dir !== 1'b0 || data_oe_n_i !== 1'b0) faults_o += 1;
        held = data_i;
        if (!bus_i.upper_byte_strobe_n) word_o[15:8] = data_i[15:8];
        if (!bus_i.lower_byte_strobe_n) word_o[7:0] = data_i[7:0];
        // stored first, then one ack per strobe
        #(delay_i) ack_low_o = !bus_i.address_strobe_n;
        acked = ack_low_o;
        took = ack_low_o;
        // release clears acked long before 85 ns, so the hold check keeps its own flag
        #85 if (took && (data_oe_n_i !== 1'b0 || data_i !== held)) faults_o += 1;
    end
    // let go soon after the first strobe rises; pull-ups bring lines high
    always @(posedge bus_i.address_strobe_n or posedge bds_n) begin
        #20 {ack_low_o, match_low_o} = 2'b00;
        #5 if (acked && (bus_oe_n_i | bus_i.read_write_dir) !== 1'b0) faults_o += 1;
        acked = 1'b0;
    end
endmodule
`default_nettype wire

// file: bench/async_bus_slave_write_cycle_bench.sv
// self-checking bench: random backplane writes against a slave card model
`timescale 1ns/100ps
`default_nettype none
module async_bus_slave_write_cycle_bench;
    import wr_master_pkg::*;
    localparam logic [2:0] PAGE = 3'h2;  // page the model answers
    logic        clock_i, rstn_i, req_valid_i, req_ready_o, done_o, bus_error_o;
    logic        matched_o, bus_oe_n_o, data_oe_n_o, transfer_ack_o, transfer_ack_oe_n_o;
    logic        ack_low, match_low;
    wr_req_t     req_i;
    bus_out_t    bus_o;
    logic [15:0] data_lines_o, word, exp;
    logic [10:0] delay;
    logic [7:0]  faults;
    logic [31:0] seed = 32'h0000004D;  // xorshift state, starts at 77
    int          miscompares, comparisons, as_lo, dir_lo, oe_lo, quiet, ack_lo, cyc;
    logic        as_q, bds_q;
    wire logic   ack_line   = !ack_low;  // resistor and active pull-up both give high
    wire logic   match_line = !match_low;
    wire logic   bds_n = bus_o.upper_byte_strobe_n & bus_o.lower_byte_strobe_n;
    wr_master #(.AS_TO_DS_CYC(AS_DS_MIN_CYC)) dut (.clock_i, .rstn_i, .req_valid_i, .req_i,
        .req_ready_o, .done_o, .bus_error_o, .matched_o, .bus_o, .bus_oe_n_o, .data_lines_o,
        .data_oe_n_o, .transfer_ack_o, .transfer_ack_oe_n_o, .transfer_ack_n_i(ack_line),
        .address_match_n_i(match_line));
    slave_model #(.PAGE(PAGE)) card (.bus_i(bus_o), .bus_oe_n_i(bus_oe_n_o),
        .data_i(data_lines_o), .data_oe_n_i(data_oe_n_o), .delay_i(delay),
        .ack_low_o(ack_low), .match_low_o(match_low), .word_o(word), .faults_o(faults));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // only strobed lanes change the stored word
    function logic [15:0] merge(input logic [15:0] old, input wr_req_t r);
        return {r.upper_en ? r.data[15:8] : old[15:8], r.lower_en ? r.data[7:0] : old[7:0]};
    endfunction
    task automatic chk_bit(input logic got, input logic want);
        comparisons++;
        if (got !== want) begin
            miscompares++;
            $display("[ERR] %0t flag %b, expected %b", $time, got, want);
        end
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] want);
        comparisons++;
        if (got !== want) begin
            miscompares++;
            $display("[ERR] %0t word %h, expected %h", $time, got, want);
        end
    endtask
    task automatic chk_cnt(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic tally_and_finish();
        chk_word({8'h00, faults}, 16'h0000);
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // wire-timing monitor in whole cycles, sampled on the design's own edge
    always @(posedge clock_i) if (rstn_i) begin
        if (!bus_o.address_strobe_n && as_q) begin
            chk_cnt(oe_lo, ADDR_SETUP_CYC, 9999);
            chk_cnt(dir_lo, 0, RW_EARLY_NS / CLK_PERIOD_NS);
            chk_cnt(quiet, TAKEOVER_CYC, 99999);
            // codes and low address must be the ones asked for when the strobe falls
            chk_word({bus_o.function_code_lines, bus_o.addr[12:0]},
                     {req_i.fc, req_i.addr[12:0]});
        end
        if (!bds_n && bds_q) begin
            chk_cnt(as_lo, AS_DS_MIN_CYC, AS_DS_MAX_CYC);
            chk_cnt(dir_lo, RW_DS_CYC, 9999);
            chk_cnt(oe_lo, ADDR_SETUP_CYC + AS_DS_MIN_CYC, 9999);
        end
        if (bus_o.address_strobe_n && !as_q) begin
            chk_cnt(as_lo, 1, AS_LOW_MAX_CYC);
            chk_cnt(ack_lo, 0, NEGATE_MAX_CYC);
        end
        if (!bus_o.address_strobe_n) chk_bit(transfer_ack_oe_n_o, 1'b1);
        else if (!transfer_ack_oe_n_o) chk_bit(transfer_ack_o, 1'b1);
        as_lo = bus_o.address_strobe_n ? 0 : as_lo + 1;
        dir_lo = bus_o.read_write_dir ? 0 : dir_lo + 1;
        oe_lo = (bus_oe_n_o | data_oe_n_o) ? 0 : oe_lo + 1;
        quiet = (bus_o.address_strobe_n && ack_line) ? quiet + 1 : 0;
        ack_lo = bus_o.address_strobe_n ? 0 : ack_lo + int'(!ack_line);
        as_q = bus_o.address_strobe_n;
        bds_q = bds_n;
    end
    // hang guard, well above the longest expected run
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    // one write: hold valid until taken, then wait for done or bus error
    task automatic write(input wr_req_t r, input logic [10:0] d);
        int  n;
        int  lim;
        logic hit;
        @(negedge clock_i);
        req_i = r;
        req_valid_i = 1'b1;
        delay = d;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 500) begin
            @(negedge clock_i);
            n++;
        end
        @(negedge clock_i);
        req_valid_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && bus_error_o !== 1'b1 && n < 400) begin
            @(negedge clock_i);
            n++;
        end
        hit = r.addr[22:20] == PAGE && (r.upper_en | r.lower_en);
        lim = r.dma ? ACK_LIMIT_DMA_CYC : ACK_LIMIT_CYC;
        chk_bit(done_o, hit);
        chk_bit(bus_error_o, !hit);
        if (hit) exp = merge(exp, r);
        else chk_cnt(n, lim, lim + 12);
        repeat (3) @(negedge clock_i);
        chk_bit(matched_o, r.addr[22:20] == PAGE);
        chk_word(word, exp);
    endtask
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    initial begin
        logic [63:0] v;
        wr_req_t     r;
        {rstn_i, req_valid_i, as_q, bds_q} = 4'h3;
        req_i = '0;
        delay = 11'h000;
        exp = 16'h0000;
        repeat (20) @(negedge clock_i);
        rstn_i = 1'b1;
        // corners: prompt full word, slow lower lane, quick upper lane, no lanes, off page dma, slow dma
        write({PAGE, 20'h00001, 3'h5, 16'hA55A, 3'h6}, 11'h000);
        write({PAGE, 20'h00002, 3'h1, 16'h1234, 3'h2}, 11'h3E7);
        write({PAGE, 20'h00003, 3'h2, 16'hFEDC, 3'h4}, 11'h010);
        write({PAGE, 20'h00004, 3'h3, 16'h0F0F, 3'h0}, 11'h000);
        write({3'h5, 20'h00005, 3'h6, 16'hBEEF, 3'h7}, 11'h000);
        write({PAGE, 20'h00006, 3'h7, 16'h5AA5, 3'h7}, 11'h3E7);
        for (int i = 0; i < 40; i++) begin
            v = {rnd(), rnd()};
            r = v[44:0];
            if (v[50]) r.addr[22:20] = PAGE;
            write(r, 11'(rnd() % 1000));
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
